//--- core/mtc_pkg.sv
package mtc_pkg;
  // Register indices on the 8-bit register port
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT_HIGH     = 4'h1;
  localparam logic [3:0] ADDR_COUNT_LOW      = 4'h2;
  localparam logic [3:0] ADDR_MOD_HIGH       = 4'h3;
  localparam logic [3:0] ADDR_MOD_LOW        = 4'h4;
  localparam logic [3:0] ADDR_CH0_SC         = 4'h5;
  localparam logic [3:0] ADDR_CH0_HIGH       = 4'h6;
  localparam logic [3:0] ADDR_CH0_LOW        = 4'h7;
  localparam logic [3:0] ADDR_CH1_SC         = 4'h8;
  localparam logic [3:0] ADDR_CH1_HIGH       = 4'h9;
  localparam logic [3:0] ADDR_CH1_LOW        = 4'hA;

  // Timer status and control field positions
  localparam int BIT_OVF   = 7;
  localparam int BIT_OVIE  = 6;
  localparam int BIT_HALT  = 5;
  localparam int BIT_CLR   = 4;
  localparam int BIT_PS_HI = 2;
  // Channel status and control field positions
  localparam int BIT_CHF   = 7;
  localparam int BIT_CHIE  = 6;
  localparam int BIT_MODE  = 4;
  localparam int BIT_EDGE1 = 3;
  localparam int BIT_EDGE0 = 2;

  // Reset and special values
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] MODULUS_RESET = 16'hFFFF;
  localparam logic [2:0]  PS_RESET      = 3'h0;
  localparam logic [2:0]  PS_EXTERNAL   = 3'h7;
  localparam logic [5:0]  PRESCALE_ZERO = 6'h00;
  localparam logic [7:0]  READ_ZERO     = 8'h00;

  // One 16-bit channel with its control bits
  typedef struct packed {
    logic        flag;
    logic        irq_en;
    logic        compare;
    logic [1:0]  edge_sel;
    logic [15:0] value;
    logic        capture_hold;
    logic        compare_hold;
    logic        clear_armed;
  } mtc_chan_s;
endpackage

//--- core/mtc_core.sv
// Functional notes
// - Stop input halts counting and flags; all state is kept.
// - Break state stops the counter from incrementing.
// - With break clear enable set, flags may be cleared during break.
// - With break clear enable low, accesses in break leave flags alone.
// - Prescale select 111 clocks the counter from the external pin.
// - External clock pin is forced to input while selected.
// - Overflow flag sets on the tick that wraps the counter from the modulus.
// - Overflow flag clears by read-with-set then write 0; new event wins.
// - Overflow request is flag and enable, masked while a modulus high byte waits; reset clears the enable.
// - Halt bit stops counting; reset sets it.
// - Clear bit zeroes counter and prescaler, self-clears, reads 0.
// - Halt and clear written together leave the counter stopped at 0.
// - Select codes 000..110 divide the bus clock by 1 to 64.
// - High count read latches low byte until low byte is read.
// - At the modulus the counter loads zero on the next tick.
// - Modulus high write suppresses overflow until low is written.
// - Modulus resets to all ones.
// - Channel flag sets on capture edge or compare match.
// - Channel flag clears by read-with-set then write 0 when enabled.
// - Counter updates once per tick in the bus clock domain.
`timescale 1ns/10ps
module mtc_core (
  // Clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_B_I,
  // Register port
  input  wire logic [3:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // System state
  input  wire logic       STOP_MODE_I,
  input  wire logic       BREAK_I,
  input  wire logic       BREAK_CLEAR_EN_I,
  // Pins
  input  wire logic       EXT_CLK_I,
  output logic            EXT_CLK_IN_FORCE_O,
  input  wire logic       CH0_PIN_I,
  input  wire logic       CH1_PIN_I,
  // Interrupt requests
  output logic            OVF_IRQ_O,
  output logic            CH0_IRQ_O,
  output logic            CH1_IRQ_O
);

  // Timer state
  // Counter, modulus and prescaler; the modulus high byte waits in a
  // buffer until the low byte commits both halves together
  logic [15:0] count_r;
  logic [15:0] modulus_r;
  logic [7:0]  mod_high_buf_r;
  logic        mod_hold_r;
  logic [5:0]  prescale_r;
  logic [2:0]  ps_sel_r;
  logic        halt_r;
  logic        ovf_r;
  logic        ovf_ie_r;
  logic        ovf_armed_r;
  // Read-side latch for the count low byte and the sampled pin history;
  // the history feeds edge detection only, never a data path
  logic [7:0]  low_latch_r;
  logic        low_latched_r;
  logic        ext_d1_r;
  logic        ext_d2_r;
  logic [1:0]  ch0_pin_r;
  logic [1:0]  ch1_pin_r;
  // Channel state, one packed record per channel
  mtc_pkg::mtc_chan_s ch_r [2];

  // Decode of accesses; status flags cannot be armed or cleared in break without enable
  // Only the arming read and the clearing write are gated; ordinary
  // register writes still land during break so software can set up.
  // A clear armed before the break survives it and completes afterwards.
  wire flag_access = !BREAK_I || BREAK_CLEAR_EN_I;
  wire wr_sc   = WR_I && (ADDR_I == mtc_pkg::ADDR_STATUS_CONTROL);
  wire rd_sc   = RD_I && (ADDR_I == mtc_pkg::ADDR_STATUS_CONTROL);
  wire rd_cnth = RD_I && (ADDR_I == mtc_pkg::ADDR_COUNT_HIGH);
  wire rd_cntl = RD_I && (ADDR_I == mtc_pkg::ADDR_COUNT_LOW);
  wire wr_modh = WR_I && (ADDR_I == mtc_pkg::ADDR_MOD_HIGH);
  wire wr_modl = WR_I && (ADDR_I == mtc_pkg::ADDR_MOD_LOW);
  wire clr_req = wr_sc && WDATA_I[mtc_pkg::BIT_CLR];

  // Prescaler tap: divide by 2^select, all ones on the chosen width
  // Select 0 gives an empty mask, so every run cycle is a tick;
  // select 6 needs six ones, one tick in sixty-four
  function automatic logic tap_hit(input logic [5:0] pre,
                                   input logic [2:0] sel);
    logic [5:0] mask;
    mask = 6'(6'h3F >> (3'd6 - sel));
    return (pre & mask) == mask;
  endfunction

  // Edge select test used by both capture channels
  // Bit 0 of the pin history is the newer sample, bit 1 the older;
  // enabling both edge bits captures on either edge
  function automatic logic edge_hit(input logic [1:0] pin,
                                    input logic [1:0] sel);
    return (sel[0] && pin[0] && !pin[1]) ||
           (sel[1] && !pin[0] && pin[1]);
  endfunction

  // Tick generation: the external pin is sampled, so it must be slow
  // A free-running source faster than half the bus rate loses edges
  // here, and nothing reports that loss to software.
  // At the modulus the counter wraps to zero and flags on the same tick;
  // a modulus below the current count lets it run through all ones first
  wire ext_rise  = ext_d1_r && !ext_d2_r;
  wire use_ext   = (ps_sel_r == mtc_pkg::PS_EXTERNAL);
  wire run       = !halt_r && !BREAK_I && !STOP_MODE_I;
  wire int_tick  = tap_hit(prescale_r, ps_sel_r);
  wire tick      = run && (use_ext ? ext_rise : int_tick);
  wire at_mod    = (count_r == modulus_r);
  wire ovf_set   = tick && at_mod && !mod_hold_r;
  wire [15:0] count_nxt = at_mod ? mtc_pkg::COUNT_RESET
                                 : 16'(count_r + 16'h0001);

  // Overflow flag two-step clear, set wins over the clear
  // The clear acts only once the arming read has seen the flag set;
  // writing one to the flag bit never changes it
  wire ovf_clear = wr_sc && flag_access && ovf_armed_r &&
                   !WDATA_I[mtc_pkg::BIT_OVF];

  // Read data selection; clear bit always reads zero
  // Unmapped indices read zero; the channel byte keeps bit 5 empty
  // so the mode bit sits where software expects it
  wire [7:0] sc_rd = {ovf_r, ovf_ie_r, halt_r, 1'b0, 1'b0, ps_sel_r};
  function automatic logic [7:0] ch_sc(input mtc_pkg::mtc_chan_s c);
    return {c.flag, c.irq_en, 1'b0, c.compare, c.edge_sel, 2'b00};
  endfunction
  logic [7:0] rd_mux;
  always_comb begin
    case (ADDR_I)
      mtc_pkg::ADDR_STATUS_CONTROL: rd_mux = sc_rd;
      mtc_pkg::ADDR_COUNT_HIGH:     rd_mux = count_r[15:8];
      mtc_pkg::ADDR_COUNT_LOW:      rd_mux = low_latched_r ? low_latch_r
                                                           : count_r[7:0];
      mtc_pkg::ADDR_MOD_HIGH:       rd_mux = modulus_r[15:8];
      mtc_pkg::ADDR_MOD_LOW:        rd_mux = modulus_r[7:0];
      mtc_pkg::ADDR_CH0_SC:         rd_mux = ch_sc(ch_r[0]);
      mtc_pkg::ADDR_CH0_HIGH:       rd_mux = ch_r[0].value[15:8];
      mtc_pkg::ADDR_CH0_LOW:        rd_mux = ch_r[0].value[7:0];
      mtc_pkg::ADDR_CH1_SC:         rd_mux = ch_sc(ch_r[1]);
      mtc_pkg::ADDR_CH1_HIGH:       rd_mux = ch_r[1].value[15:8];
      mtc_pkg::ADDR_CH1_LOW:        rd_mux = ch_r[1].value[7:0];
      default:                      rd_mux = mtc_pkg::READ_ZERO;
    endcase
  end

  // Read data register, valid only the cycle after the strobe
  // Returning zero outside the read slot keeps a shared bus quiet
  // and makes a stale value impossible to mistake for fresh data
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= mtc_pkg::READ_ZERO;
    end else begin
      RDATA_O <= RD_I ? rd_mux : mtc_pkg::READ_ZERO;
    end
  end

  // Pin sampling; second stage only feeds the edge detectors
  // Reset values match a low idle pin; a pin resting high would give
  // one false rising edge after reset if a channel captured on rises.
  // Sampling keeps running in stop; the stop gate sits on the capture.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ext_d1_r  <= 1'b0;
      ext_d2_r  <= 1'b0;
      ch0_pin_r <= 2'b00;
      ch1_pin_r <= 2'b00;
    end else begin
      ext_d1_r  <= EXT_CLK_I;
      ext_d2_r  <= ext_d1_r;
      ch0_pin_r <= {ch0_pin_r[0], CH0_PIN_I};
      ch1_pin_r <= {ch1_pin_r[0], CH1_PIN_I};
    end
  end

  // Control register and counter; clear beats a tick in the same cycle
  // The halt bit written together with the clear bit lands on the same
  // edge, so the counter stops at zero with no extra tick.
  // The prescaler only advances while running, so a halt keeps phase
  // and counting resumes mid-period unless software also clears it.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      halt_r     <= 1'b1;
      ovf_ie_r   <= 1'b0;
      ps_sel_r   <= mtc_pkg::PS_RESET;
      count_r    <= mtc_pkg::COUNT_RESET;
      prescale_r <= mtc_pkg::PRESCALE_ZERO;
    end else begin
      if (wr_sc) begin
        halt_r   <= WDATA_I[mtc_pkg::BIT_HALT];
        ovf_ie_r <= WDATA_I[mtc_pkg::BIT_OVIE];
        ps_sel_r <= WDATA_I[mtc_pkg::BIT_PS_HI:0];
      end
      if (clr_req) begin
        count_r    <= mtc_pkg::COUNT_RESET;
        prescale_r <= mtc_pkg::PRESCALE_ZERO;
      end else begin
        if (run) prescale_r <= 6'(prescale_r + 6'h01);
        if (tick) count_r <= count_nxt;
      end
    end
  end

  // Modulus pair with high-byte buffer and overflow suppression
  // The old modulus keeps governing the wrap while the high byte waits,
  // only the flag and its request are held back until the low write
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      modulus_r      <= mtc_pkg::MODULUS_RESET;
      mod_high_buf_r <= mtc_pkg::MODULUS_RESET[15:8];
      mod_hold_r     <= 1'b0;
    end else if (wr_modh) begin
      mod_high_buf_r <= WDATA_I;
      mod_hold_r     <= 1'b1;
    end else if (wr_modl) begin
      modulus_r  <= {mod_high_buf_r, WDATA_I};
      mod_hold_r <= 1'b0;
    end
  end

  // Overflow flag with two-step clear; a new overflow disarms the clear
  // Reset drops the flag and any pending arm; the enable lives in the
  // control register block. A set in the clearing cycle wins, so an
  // overflow can never be lost to a clear that was already under way.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ovf_r       <= 1'b0;
      ovf_armed_r <= 1'b0;
    end else begin
      if (ovf_set) begin
        ovf_r       <= 1'b1;
        ovf_armed_r <= 1'b0;
      end else if (ovf_clear) begin
        ovf_r       <= 1'b0;
        ovf_armed_r <= 1'b0;
      end else if (rd_sc && ovf_r && flag_access) begin
        ovf_armed_r <= 1'b1;
      end
    end
  end

  // Count low-byte latch on a high-byte read
  // A latch left set across a break keeps the old low byte until the
  // next low-byte read, so software should release it before resuming.
  // A lone low-byte read with no latch set returns the live count.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      low_latch_r   <= mtc_pkg::READ_ZERO;
      low_latched_r <= 1'b0;
    end else if (rd_cntl) begin
      low_latched_r <= 1'b0;
    end else if (rd_cnth && !low_latched_r) begin
      low_latch_r   <= count_r[7:0];
      low_latched_r <= 1'b1;
    end
  end

  // Channels: capture or compare, two-step flag clear per channel
  // A capture-mode high read holds captures until the low read;
  // a compare-mode high write holds compares until the low write.
  // The flag clear needs the interrupt enable; with it off the flag stays
  for (genvar i = 0; i < 2; i++) begin : g_ch
    // Per-channel register indices and pin history
    localparam logic [3:0] A_SC = i ? mtc_pkg::ADDR_CH1_SC
                                    : mtc_pkg::ADDR_CH0_SC;
    localparam logic [3:0] A_HI = i ? mtc_pkg::ADDR_CH1_HIGH
                                    : mtc_pkg::ADDR_CH0_HIGH;
    localparam logic [3:0] A_LO = i ? mtc_pkg::ADDR_CH1_LOW
                                    : mtc_pkg::ADDR_CH0_LOW;
    wire [1:0] pin = i ? ch1_pin_r : ch0_pin_r;
    // Per-channel access decodes
    wire c_wr_sc = WR_I && (ADDR_I == A_SC);
    wire c_rd_sc = RD_I && (ADDR_I == A_SC);
    wire c_wr_hi = WR_I && (ADDR_I == A_HI);
    wire c_wr_lo = WR_I && (ADDR_I == A_LO);
    wire c_rd_hi = RD_I && (ADDR_I == A_HI);
    wire c_rd_lo = RD_I && (ADDR_I == A_LO);
    // Capture runs off pin edges even while the counter is halted
    wire cap = !ch_r[i].compare && !ch_r[i].capture_hold &&
               !STOP_MODE_I && edge_hit(pin, ch_r[i].edge_sel);
    wire cmp = ch_r[i].compare && !ch_r[i].compare_hold && tick &&
               (count_r == ch_r[i].value);
    wire ev  = cap || cmp;
    // Value, control bits and flag of one channel; an event beats a clear
    wire clr = c_wr_sc && flag_access && ch_r[i].irq_en &&
               ch_r[i].clear_armed && !WDATA_I[mtc_pkg::BIT_CHF];
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
        ch_r[i] <= '0;
      end else begin
        if (c_wr_sc) begin
          ch_r[i].irq_en   <= WDATA_I[mtc_pkg::BIT_CHIE];
          ch_r[i].compare  <= WDATA_I[mtc_pkg::BIT_MODE];
          ch_r[i].edge_sel <= WDATA_I[mtc_pkg::BIT_EDGE1:
                                      mtc_pkg::BIT_EDGE0];
        end
        if (cap) ch_r[i].value <= count_r;
        else if (c_wr_hi) begin
          ch_r[i].value[15:8]   <= WDATA_I;
          ch_r[i].compare_hold  <= ch_r[i].compare;
        end else if (c_wr_lo) begin
          ch_r[i].value[7:0]    <= WDATA_I;
          ch_r[i].compare_hold  <= 1'b0;
        end
        if (c_rd_hi && !ch_r[i].compare) ch_r[i].capture_hold <= 1'b1;
        else if (c_rd_lo) ch_r[i].capture_hold <= 1'b0;
        if (ev) begin
          ch_r[i].flag        <= 1'b1;
          ch_r[i].clear_armed <= 1'b0;
        end else if (clr) begin
          ch_r[i].flag        <= 1'b0;
          ch_r[i].clear_armed <= 1'b0;
        end else if (c_rd_sc && ch_r[i].flag && flag_access) begin
          ch_r[i].clear_armed <= 1'b1;
        end
      end
    end
  end

  // Registered request and pin-direction outputs
  // Requests are registered, so they trail their flag by one cycle.
  // The force-input level follows select 111 alone, whatever the port
  // direction setting holds, so the pin cannot fight the clock source
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      OVF_IRQ_O          <= 1'b0;
      CH0_IRQ_O          <= 1'b0;
      CH1_IRQ_O          <= 1'b0;
      EXT_CLK_IN_FORCE_O <= 1'b0;
    end else begin
      OVF_IRQ_O <= ovf_r && ovf_ie_r && !mod_hold_r;
      CH0_IRQ_O <= ch_r[0].flag && ch_r[0].irq_en;
      CH1_IRQ_O <= ch_r[1].flag && ch_r[1].irq_en;
      EXT_CLK_IN_FORCE_O <= use_ext;
    end
  end

endmodule

//--- testbench/mtc_ext_src.sv
`timescale 1ns/10ps
module mtc_ext_src (
  // Bus clock and burst control
  input  wire logic clk_i,
  input  wire logic run_i,
  // External timer clock
  output logic      ext_clk_o
);
  logic ph_r;
  logic tog_r;
  // One rise per four bus cycles stays under half the bus rate
  always_ff @(posedge clk_i) begin
    ph_r  <= run_i & ~ph_r;
    tog_r <= run_i & (tog_r ^ ph_r);
  end
  // Gated so the line parks low outside bursts, also at time zero
  assign ext_clk_o = tog_r & run_i;
endmodule

//--- testbench/mtc_core_properties.sv
`timescale 1ns/10ps
module mtc_core_props (
  // Clock and reset
  input wire logic       CORE_CLK_I,
  input wire logic       RST_B_I,
  // Register port
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  // System state
  input wire logic       STOP_MODE_I,
  input wire logic       BREAK_I,
  // Pin control and requests
  input wire logic       EXT_CLK_IN_FORCE_O,
  input wire logic       OVF_IRQ_O,
  input wire logic       CH0_IRQ_O
);
  localparam logic [3:0] A_ST = mtc_pkg::ADDR_STATUS_CONTROL;
  localparam logic [3:0] A_CL = mtc_pkg::ADDR_COUNT_LOW;
  localparam logic [3:0] A_ML = mtc_pkg::ADDR_MOD_LOW;
  localparam logic [3:0] A_CS = mtc_pkg::ADDR_CH0_SC;
  // Access decodes
  wire st_wr = WR_I && ADDR_I == A_ST;
  wire cl_rd = RD_I && ADDR_I == A_CL;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Register port timing and fixed read values
  read_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside read slot");
  clear_reads_zero_a: assert property ($past(RD_I && ADDR_I == A_ST)
    |-> !RDATA_O[mtc_pkg::BIT_CLR]) else $error("clear bit read as one");
  mod_readback_a: assert property (RD_I && ADDR_I == A_ML
    && $past(WR_I && ADDR_I == A_ML) |=> RDATA_O == $past(WDATA_I, 2))
    else $error("modulus low readback wrong");
  // Pin direction and request masking
  force_input_a: assert property (st_wr && WDATA_I[2:0] == 3'h7
    |-> ##[1:2] EXT_CLK_IN_FORCE_O) else $error("pin not forced input");
  ovf_mask_a: assert property (st_wr && !WDATA_I[mtc_pkg::BIT_OVIE]
    |-> ##[2:3] !OVF_IRQ_O) else $error("overflow request not masked");
  chan_mask_a: assert property (WR_I && ADDR_I == A_CS
    && !WDATA_I[mtc_pkg::BIT_CHIE] |-> ##[2:3] !CH0_IRQ_O)
    else $error("channel request not masked");
  // Count frozen: two settled reads agree
  stop_freeze_a: assert property (cl_rd && $past(cl_rd) && STOP_MODE_I
    && $past(STOP_MODE_I, 4) |=> RDATA_O == $past(RDATA_O))
    else $error("count moved in stop");
  break_freeze_a: assert property (cl_rd && $past(cl_rd) && BREAK_I
    && $past(BREAK_I, 4) |=> RDATA_O == $past(RDATA_O))
    else $error("count moved in break");
endmodule
bind mtc_core mtc_core_props i_mtc_core_props (.CORE_CLK_I, .RST_B_I,
  .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .STOP_MODE_I, .BREAK_I,
  .EXT_CLK_IN_FORCE_O, .OVF_IRQ_O, .CH0_IRQ_O);

//--- testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam logic [3:0] ST = mtc_pkg::ADDR_STATUS_CONTROL;
  localparam logic [3:0] CH = mtc_pkg::ADDR_COUNT_HIGH;
  localparam logic [3:0] CL = mtc_pkg::ADDR_COUNT_LOW;
  localparam logic [3:0] MH = mtc_pkg::ADDR_MOD_HIGH;
  localparam logic [3:0] ML = mtc_pkg::ADDR_MOD_LOW;
  localparam logic [3:0] CS = mtc_pkg::ADDR_CH0_SC;
  logic clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, stop = 1'h0;
  logic brk = 1'h0, bce = 1'h0, ext_run = 1'h0, ext_clk, force_in;
  logic ovf_irq, ch0_irq, ch1_irq, ch1_pin = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, h, l, v;
  int miscompares = 0, checks = 0;
  // Clock
  initial forever #5 clk = ~clk;
  mtc_core i_mtc_core (.CORE_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .STOP_MODE_I(stop), .BREAK_I(brk), .BREAK_CLEAR_EN_I(bce),
    .EXT_CLK_I(ext_clk), .EXT_CLK_IN_FORCE_O(force_in), .CH0_PIN_I(1'h0),
    .CH1_PIN_I(ch1_pin), .OVF_IRQ_O(ovf_irq), .CH0_IRQ_O(ch0_irq),
    .CH1_IRQ_O(ch1_irq));
  mtc_ext_src i_mtc_ext_src (.clk_i(clk), .run_i(ext_run),
    .ext_clk_o(ext_clk));
  // Shared compare, bus and wait helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  // Read data is looked at only in the cycle after the read
  task automatic rdv(input logic [3:0] a, output logic [7:0] q);
    bus(1'h0, a, 8'h00);
    #1 q = rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    rdv(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  task automatic idle(input int n);
    wr <= 1'h0;
    rd <= 1'h0;
    repeat (n) @(posedge clk);
  endtask
  // Halt, then read the count pair high byte first
  task automatic halt_count(input logic [7:0] st, input logic [15:0] e);
    wrr(ST, st);
    rdv(CH, h);
    rdv(CL, l);
    chk({h, l}, e);
    idle(1);
  endtask
  task automatic t_reset;
    rdc(ST, 8'h20);
    rdc(MH, 8'hFF);
    rdc(ML, 8'hFF);
    rdc(4'hF, 8'h00);
    chk({15'h0000, ovf_irq}, 16'h0000);
    wrr(ST, 8'h10);
    idle(20);
    wrr(ST, 8'h30);
    idle(5);
    rdc(CL, 8'h00);
    idle(1);
  endtask
  // Clear and run for 200 cycles at every internal divide
  task automatic t_prescale;
    for (int ps = 0; ps < 7; ps++) begin
      wrr(ST, {5'h02, ps[2:0]});
      idle(199);
      halt_count({5'h04, ps[2:0]}, 16'd200 >> ps);
    end
  endtask
  task automatic t_ext;
    wrr(ST, 8'h17);
    ext_run <= 1'h1;
    idle(40);
    ext_run <= 1'h0;
    idle(6);
    chk({15'h0000, force_in}, 16'h0001);
    halt_count(8'h27, 16'h000A);
  endtask
  // Second high read must not relatch the low byte
  task automatic t_latch;
    wrr(ST, 8'h10);
    idle(5);
    rdv(CH, h);
    idle(10);
    rdv(CH, h);
    idle(10);
    rdv(CL, l);
    rdv(CL, v);
    chk({15'h0000, (v - l) > 8'd18}, 16'h0001);
    chk({15'h0000, force_in}, 16'h0000);
    wrr(ST, 8'h20);
  endtask
  task automatic t_overflow;
    wrr(ST, 8'h30);
    wrr(MH, 8'h00);
    wrr(ML, 8'h05);
    wrr(ST, 8'h50);
    idle(8);
    halt_count(8'h60, 16'h0003);
    chk({15'h0000, ovf_irq}, 16'h0001);
    rdc(ST, 8'hE0);
    wrr(ST, 8'hE0);
    rdc(ST, 8'hE0);
    brk <= 1'h1;
    wrr(ST, 8'h60);
    rdc(ST, 8'hE0);
    brk <= 1'h0;
    wrr(ST, 8'h60);
    rdc(ST, 8'h60);
    idle(3);
    chk({15'h0000, ovf_irq}, 16'h0000);
  endtask
  // New overflow between arm and write voids the clear
  task automatic t_void;
    wrr(ST, 8'h50);
    idle(10);
    rdv(ST, v);
    idle(6);
    wrr(ST, 8'h40);
    wrr(ST, 8'h60);
    rdc(ST, 8'hE0);
    bce <= 1'h1;
    brk <= 1'h1;
    rdv(ST, v);
    wrr(ST, 8'h60);
    brk <= 1'h0;
    rdc(ST, 8'h60);
    bce <= 1'h0;
    idle(1);
  endtask
  task automatic t_freeze;
    wrr(ST, 8'h10);
    stop <= 1'h1;
    idle(4);
    rdv(CL, l);
    rdc(CL, l);
    stop <= 1'h0;
    brk <= 1'h1;
    idle(4);
    rdv(CL, l);
    rdc(CL, l);
    brk <= 1'h0;
    rdv(ST, v);
    wrr(ST, 8'h20);
  endtask
  task automatic t_mod_hold;
    wrr(ST, 8'h30);
    wrr(MH, 8'h00);
    wrr(ST, 8'h10);
    idle(20);
    wrr(ST, 8'h20);
    rdc(ST, 8'h20);
    wrr(ML, 8'h05);
    rdc(ML, 8'h05);
    rdc(MH, 8'h00);
    wrr(ST, 8'h10);
    idle(10);
    wrr(ST, 8'h20);
    rdc(ST, 8'hA0);
  endtask
  task automatic t_compare;
    wrr(CS, 8'h50);
    wrr(mtc_pkg::ADDR_CH0_HIGH, 8'h00);
    wrr(mtc_pkg::ADDR_CH0_LOW, 8'h03);
    wrr(ST, 8'h10);
    idle(8);
    wrr(ST, 8'h20);
    rdc(CS, 8'hD0);
    chk({15'h0000, ch0_irq}, 16'h0001);
    wrr(CS, 8'h50);
    rdc(CS, 8'h50);
    wrr(CS, 8'h10);
    idle(4);
  endtask
  // Rising edge on channel 1 captures the running count; none in stop
  task automatic t_capture;
    wrr(mtc_pkg::ADDR_CH1_SC, 8'h44);
    wrr(ST, 8'h10);
    idle(9);
    ch1_pin <= 1'h1;
    idle(4);
    wrr(ST, 8'h20);
    rdc(mtc_pkg::ADDR_CH1_HIGH, 8'h00);
    rdc(mtc_pkg::ADDR_CH1_LOW, 8'h04);
    rdc(mtc_pkg::ADDR_CH1_SC, 8'hC4);
    chk({15'h0000, ch1_irq}, 16'h0001);
    wrr(mtc_pkg::ADDR_CH1_SC, 8'h44);
    rdc(mtc_pkg::ADDR_CH1_SC, 8'h44);
    chk({15'h0000, ch1_irq}, 16'h0000);
    stop <= 1'h1;
    ch1_pin <= 1'h0;
    idle(3);
    ch1_pin <= 1'h1;
    idle(3);
    stop <= 1'h0;
    rdc(mtc_pkg::ADDR_CH1_SC, 8'h44);
  endtask
  task automatic test_done;
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    t_reset();
    t_prescale();
    t_ext();
    t_latch();
    t_overflow();
    t_void();
    t_freeze();
    t_mod_hold();
    t_compare();
    t_capture();
    test_done();
  end
  // Watchdog well beyond the fewer than two thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("mismatch at %0t: timeout", $time);
    test_done();
  end
endmodule
